/* pkg/dcsw_pkg.sv */
/*
 Constants, field layouts and carrier types of the drive command/state word block.
 Assumes a 32-bit classic Wishbone slave and one 200 MHz clock.
*/
package dcsw_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_REF = 8'h04;
    localparam logic [7:0] OFS_STATE = 8'h08;
    localparam logic [7:0] OFS_ACTF = 8'h0C;
    localparam logic [7:0] OFS_CFG = 8'h10;
    localparam logic [7:0] OFS_STEP = 8'h14;
    localparam logic [7:0] OFS_LIM = 8'h18;
    localparam logic [7:0] OFS_CTRL = 8'h1C;

    // ==========================================================
    // Command word bit positions
    localparam int CW_OFF1 = 0;
    localparam int CW_OFF2 = 1;
    localparam int CW_OFF3 = 2;
    localparam int CW_COAST = 3;
    localparam int CW_QSTOP = 4;
    localparam int CW_HOLD = 5;
    localparam int CW_START = 6;
    localparam int CW_RESET = 7;
    localparam int CW_JOG1 = 8;
    localparam int CW_JOG2 = 9;
    localparam int CW_VALID = 10;
    localparam int CW_SLOW = 11;
    localparam int CW_CATCH = 12;
    localparam int CW_SET_LO = 13;
    localparam int CW_SET_HI = 14;
    localparam int CW_REV = 15;

    // ==========================================================
    // Configuration register fields and reset values
    localparam int CFG_MULTI = 0;
    localparam int CFG_LINKED = 1;
    localparam int CFG_RELAY = 2;
    localparam int CFG_REVSRC = 4;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [15:0] CMD_RST = 16'h0000;
    localparam logic [15:0] REF_RST = 16'h0000;
    localparam logic [15:0] STEP_RST = 16'h0000;
    localparam logic [15:0] LIM_LO_RST = 16'hC000;
    localparam logic [15:0] LIM_HI_RST = 16'h4000;
    localparam logic [15:0] REF_FULL = 16'h4000;
    localparam logic [15:0] REF_MAX = 16'h7FFF;
    localparam logic [15:0] REF_MIN = 16'h8000;

    typedef enum logic [1:0] {
        REV_DIN = 2'h0,
        REV_BUS = 2'h1,
        REV_AND = 2'h2,
        REV_OR = 2'h3
    } dcsw_revsrc_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic ctrl_ready;
        logic power_ok;
        logic trip;
        logic trip_lock;
        logic error;
        logic warning;
        logic local_stop;
        logic local_ref;
        logic start;
        logic overtemp_halt;
        logic dc_volt_warn;
        logic cur_limit;
        logic motor_timer_over;
        logic drive_timer_over;
        logic link_lost;
        logic comm_fault;
        logic rev_din;
    } dcsw_mon_t;

    typedef struct packed {
        logic ramp_stop;
        logic coast_stop;
        logic quick_stop;
        logic freeze;
        logic jog1;
        logic jog2;
        logic reverse;
        logic [1:0] setup_sel;
        logic zero_relay;
        logic fault_reset;
    } dcsw_drv_t;

endpackage

/* verilog/dcsw_ref_step.sv */
/*
 Registered slow-down/catch-up adjustment of the signed bus speed reference.
 Assumes a synchronous active-high reset on the same clock as the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module dcsw_ref_step (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] ref_i,
    input wire logic [15:0] step_i,
    input wire logic slow_i,
    input wire logic catch_i,
    output logic [15:0] ref_o
);
    import dcsw_pkg::*;

    logic signed [16:0] sum_next;

    // ==========================================================
    // Adjust and saturate
    // Slow-down is tested first so it wins when both are requested.
    always_comb begin
        if (slow_i) begin
            sum_next = 17'($signed(ref_i)) - 17'($signed({1'b0, step_i}));
        end else if (catch_i) begin
            sum_next = 17'($signed(ref_i)) + 17'($signed({1'b0, step_i}));
        end else begin
            sum_next = 17'($signed(ref_i));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_o <= REF_RST;
        end else if (sum_next > 17'sd32767) begin
            ref_o <= REF_MAX;
        end else if (sum_next < -17'sd32768) begin
            ref_o <= REF_MIN;
        end else begin
            ref_o <= sum_next[15:0];
        end
    end
endmodule
`default_nettype wire

/* verilog/dcsw_state_word.sv */
/*
 Builds the registered 16-bit drive state word from monitor levels.
 Assumes all inputs are on the caller's clock; trip_held is already latched.
*/
`timescale 1ns/1ps
`default_nettype none
module dcsw_state_word (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dcsw_pkg::dcsw_mon_t mon_i,
    input wire logic trip_held_i,
    input wire logic coasting_i,
    input wire logic at_ref_i,
    input wire logic in_limits_i,
    input wire logic running_i,
    output logic [15:0] word_o
);
    import dcsw_pkg::*;

    logic [15:0] word_next;
    logic ready;

    always_comb begin
        ready = mon_i.ctrl_ready & ~trip_held_i;
        word_next = 16'h0000;
        word_next[0] = ready;
        word_next[1] = ready & mon_i.power_ok;
        word_next[2] = ~coasting_i & ~trip_held_i;
        word_next[3] = trip_held_i;
        word_next[4] = mon_i.error;
        word_next[5] = 1'b0;
        word_next[6] = mon_i.trip_lock;
        word_next[7] = mon_i.warning;
        word_next[8] = at_ref_i;
        word_next[9] = ~mon_i.local_stop & ~mon_i.local_ref;
        word_next[10] = in_limits_i;
        word_next[11] = running_i;
        word_next[12] = mon_i.overtemp_halt;
        word_next[13] = mon_i.dc_volt_warn;
        word_next[14] = mon_i.cur_limit;
        word_next[15] = mon_i.motor_timer_over | mon_i.drive_timer_over;
        // A lost option link means nothing in the word can be trusted.
        if (mon_i.link_lost | mon_i.comm_fault) begin
            word_next = 16'h0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_o <= 16'h0000;
        end else begin
            word_o <= word_next;
        end
    end
endmodule
`default_nettype wire

/* verilog/dcsw_top.sv */
/*
 Drive command word decoder and state word builder behind a classic
 Wishbone slave. Monitor levels come from drive logic on the same clock.
 Decoded stop, jog, set-up and reverse levels go back to the drive.
*/
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - State bit 0 is 0 while tripped, 1 when controls are ready.
// - State bit 3 holds the trip until a reset command arrives.
// - Bit 4 shows a non-tripping error, bit 6 a trip lock.
// - Bit 7 is 1 while any warning is active.
// - Bit 8 is 1 when motor speed equals the speed reference.
// - Bit 9 is 1 unless local stop or local reference is active.
// - Bit 10 is 1 while output frequency is within both limits.
// - Bit 11 is 1 with a start signal or nonzero output frequency.
// - Bit 12 shows an overtemperature halt that recovers by itself.
// - Bit 13 shows a DC link voltage warning.
// - Bit 14 shows the current or torque limit exceeded.
// - Bit 15 shows either thermal timer beyond full scale.
// - Link loss or internal fault forces the whole state word to zero.
// - Reference and actual frequency are signed, 4000 hex is full speed.
// - A command word with bit 10 clear is ignored entirely.
// - Fault reset only on a rising edge of command bit 7.
// - Bits 0, 1, 2 low give ramp, coast, quick stop; relay at zero.
// - Bits 3..6 low give coast, quick stop, hold, ramp stop; here bit 4 low gives no quick stop while bits 0..3 are high.
// - Bits 8, 9 select jog speeds when bit 4 low, bits 0..3 high.
// - Bit 11 lowers, bit 12 raises the reference; lowering wins.
// - Bits 13, 14 pick set-up when multi-set-up allowed.
// - Bit 15 reverses only with bus, AND or OR reversing source.
module dcsw_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire dcsw_pkg::dcsw_mon_t mon_i,
    input wire logic [15:0] act_freq_i,
    output dcsw_pkg::dcsw_drv_t drv_o,
    output logic [15:0] speed_ref_o
);
    import dcsw_pkg::*;

    // ==========================================================
    // Declarations
    logic [15:0] cmd_reg;
    logic [15:0] cmd_next;
    logic [15:0] ref_reg;
    logic [15:0] ref_next;
    logic [31:0] cfg_reg;
    logic [31:0] cfg_next;
    logic [15:0] step_reg;
    logic [15:0] step_next;
    logic [15:0] lim_lo_reg;
    logic [15:0] lim_hi_reg;
    logic [31:0] lim_next;
    logic [15:0] act_reg;
    logic [15:0] state_word;
    logic trip_held_reg;
    logic rst_pulse;
    logic wr_cmd;
    logic cmd_valid;
    logic req;
    logic wr;
    logic jog_ok;
    logic running;
    logic at_ref;
    logic in_limits;
    logic zero_freq;
    logic setup_ok;
    logic [31:0] rd_data;
    logic [15:0] adj_ref;
    dcsw_revsrc_t rev_src;

    // ==========================================================
    // Wishbone request decode
    // The ack is registered, so every access takes one wait state
    // and the ack drops in the cycle after it was given.
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // Byte-lane merge for every writable register.
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] dat,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = dat[8*i +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // Command word
    // Only valid words replace the acted-upon command, so a
    // stale or partial frame never disturbs the running drive.
    assign wr_cmd = wr & (wb_adr_i == OFS_CMD);
    assign cmd_next = 16'(merge({16'h0000, cmd_reg}, wb_dat_i,
        wb_sel_i));
    assign cmd_valid = wr_cmd & cmd_next[CW_VALID];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_reg <= CMD_RST;
        end else if (cmd_valid) begin
            cmd_reg <= cmd_next;
        end
    end

    // Reset acts on the leading edge only; a held 1 does nothing.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_pulse <= 1'b0;
        end else begin
            rst_pulse <= cmd_valid & cmd_next[CW_RESET]
                         & ~cmd_reg[CW_RESET];
        end
    end

    // A trip arriving with the reset pulse stays held.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trip_held_reg <= 1'b0;
        end else if (mon_i.trip) begin
            trip_held_reg <= 1'b1;
        end else if (rst_pulse) begin
            trip_held_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Speed reference, step and configuration registers
    assign ref_next = 16'(merge({16'h0000, ref_reg}, wb_dat_i,
        wb_sel_i));
    assign step_next = 16'(merge({16'h0000, step_reg}, wb_dat_i,
        wb_sel_i));
    assign cfg_next = merge(cfg_reg, wb_dat_i, wb_sel_i);
    assign lim_next = merge({lim_hi_reg, lim_lo_reg}, wb_dat_i,
                            wb_sel_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_reg <= REF_RST;
        end else if (wr & (wb_adr_i == OFS_REF)) begin
            ref_reg <= ref_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_reg <= STEP_RST;
        end else if (wr & (wb_adr_i == OFS_STEP)) begin
            step_reg <= step_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg <= CFG_RST;
        end else if (wr & (wb_adr_i == OFS_CFG)) begin
            cfg_reg <= cfg_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lim_lo_reg <= LIM_LO_RST;
            lim_hi_reg <= LIM_HI_RST;
        end else if (wr & (wb_adr_i == OFS_LIM)) begin
            lim_lo_reg <= lim_next[15:0];
            lim_hi_reg <= lim_next[31:16];
        end
    end

    assign rev_src = dcsw_revsrc_t'(cfg_reg[CFG_REVSRC +: 2]);

    // ==========================================================
    // Reference adjustment
    dcsw_ref_step u_step (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ref_i(ref_reg),
        .step_i(step_reg),
        .slow_i(cmd_reg[CW_SLOW]),
        .catch_i(cmd_reg[CW_CATCH]),
        .ref_o(adj_ref)
    );

    assign speed_ref_o = adj_ref;

    // ==========================================================
    // Derived drive conditions
    // Comparisons are signed so reverse speeds scale like forward ones.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_reg <= 16'h0000;
        end else begin
            act_reg <= act_freq_i;
        end
    end

    assign zero_freq = (act_reg == 16'h0000);
    assign at_ref = (act_reg == adj_ref);
    assign in_limits = ($signed(act_reg) > $signed(lim_lo_reg))
                       & ($signed(act_reg) < $signed(lim_hi_reg));
    assign running = mon_i.start | ~zero_freq;
    assign jog_ok = ~cmd_reg[CW_QSTOP] & (&cmd_reg[CW_COAST:CW_OFF1]);

    // Set-up changes while running need linked set-ups.
    assign setup_ok = cfg_reg[CFG_MULTI]
                      & (~running | cfg_reg[CFG_LINKED]);

    // ==========================================================
    // Drive control outputs
    // The jog window needs bit 4 low, so quick stop is held off then.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_o.ramp_stop <= 1'b1;
            drv_o.coast_stop <= 1'b1;
            drv_o.quick_stop <= 1'b0;
            drv_o.freeze <= 1'b0;
        end else begin
            drv_o.ramp_stop <= ~cmd_reg[CW_OFF1]
                               | ~cmd_reg[CW_START];
            drv_o.coast_stop <= ~cmd_reg[CW_OFF2]
                                | ~cmd_reg[CW_COAST];
            drv_o.quick_stop <= ~cmd_reg[CW_OFF3]
                                | (~cmd_reg[CW_QSTOP] & ~jog_ok);
            drv_o.freeze <= ~cmd_reg[CW_HOLD];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_o.jog1 <= 1'b0;
            drv_o.jog2 <= 1'b0;
        end else begin
            drv_o.jog1 <= jog_ok & cmd_reg[CW_JOG1];
            drv_o.jog2 <= jog_ok & cmd_reg[CW_JOG2];
        end
    end

    // The relay marks a commanded stop that has reached standstill.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_o.zero_relay <= 1'b0;
        end else begin
            drv_o.zero_relay <= cfg_reg[CFG_RELAY] & zero_freq
                                & ~(&cmd_reg[CW_OFF3:CW_OFF1]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_o.setup_sel <= 2'h0;
        end else if (setup_ok) begin
            drv_o.setup_sel <= {cmd_reg[CW_SET_HI],
                                cmd_reg[CW_SET_LO]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_o.reverse <= 1'b0;
        end else begin
            case (rev_src)
                REV_DIN: drv_o.reverse <= mon_i.rev_din;
                REV_BUS: drv_o.reverse <= cmd_reg[CW_REV];
                REV_AND: drv_o.reverse <= cmd_reg[CW_REV]
                                          & mon_i.rev_din;
                REV_OR: drv_o.reverse <= cmd_reg[CW_REV]
                                         | mon_i.rev_din;
                default: drv_o.reverse <= 1'b0;
            endcase
        end
    end

    assign drv_o.fault_reset = rst_pulse;

    // ==========================================================
    // State word
    dcsw_state_word u_state (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mon_i(mon_i),
        .trip_held_i(trip_held_reg),
        .coasting_i(~cmd_reg[CW_COAST] | ~cmd_reg[CW_OFF2]),
        .at_ref_i(at_ref),
        .in_limits_i(in_limits),
        .running_i(running),
        .word_o(state_word)
    );

    // ==========================================================
    // Read data
    // Unmapped addresses are acknowledged and read as zero.
    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            OFS_CMD: rd_data[15:0] = cmd_reg;
            OFS_REF: rd_data[15:0] = ref_reg;
            OFS_STATE: rd_data[15:0] = state_word;
            OFS_ACTF: rd_data[15:0] = act_reg;
            OFS_CFG: rd_data = cfg_reg;
            OFS_STEP: rd_data[15:0] = step_reg;
            OFS_LIM: rd_data = {lim_hi_reg, lim_lo_reg};
            OFS_CTRL: rd_data[15:0] = {4'h0, drv_o.ramp_stop,
                drv_o.coast_stop, drv_o.quick_stop, drv_o.freeze,
                drv_o.jog1, drv_o.jog2, drv_o.reverse,
                drv_o.setup_sel, drv_o.zero_relay, trip_held_reg,
                adj_ref == REF_FULL};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req & ~wb_we_i) begin
            wb_dat_o <= rd_data;
        end
    end
endmodule
`default_nettype wire

/* bench/dcsw_checker.sv */
/*
 Concurrent checks on the ports of dcsw_top: bus handshake, state word reads
 and command decode. Assumes it is bound to dcsw_top on its single clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dcsw_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire dcsw_pkg::dcsw_mon_t mon_i,
    input wire logic [15:0] act_freq_i,
    input wire dcsw_pkg::dcsw_drv_t drv_o,
    input wire logic [15:0] speed_ref_o
);
    import dcsw_pkg::*;
    logic rd_st;
    logic link_ok;
    logic rst_cmd;
    // Read data lags monitors by two edges, so reads look back two and three cycles.
    assign rd_st = wb_ack_o && !wb_we_i && wb_adr_i == OFS_STATE;
    assign link_ok = !mon_i.link_lost && !mon_i.comm_fault;
    assign rst_cmd = wb_ack_o && wb_we_i && wb_adr_i == OFS_CMD && wb_dat_i[7] && wb_dat_i[10];
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_cmd_valid;
        wb_ack_o && wb_we_i && wb_adr_i == OFS_CMD && wb_dat_i[10];
    endsequence
    sequence s_cmd_void;
        wb_ack_o && wb_we_i && wb_adr_i == OFS_CMD && !wb_dat_i[10];
    endsequence
    // ==========================================================
    // Assertions
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    chk_hole_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h20
        |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
    chk_link_zero: assert property (
        rd_st && !$past(link_ok, 2) && !$past(link_ok, 3) |-> wb_dat_o[15:0] == 16'h0000)
        else $error("state word not cleared on link loss");
    chk_spare_zero: assert property (rd_st |-> !wb_dat_o[5])
        else $error("spare state bit set");
    chk_trip_flags: assert property (
        rd_st && $past(mon_i.trip && link_ok, 2) && $past(mon_i.trip && link_ok, 3)
        |-> wb_dat_o[3] && !wb_dat_o[0]) else $error("trip flags wrong");
    chk_warn_flag: assert property (
        rd_st && $past(mon_i.warning && link_ok, 2) && $past(mon_i.warning && link_ok, 3)
        |-> wb_dat_o[7]) else $error("warning flag missing");
    chk_coast_cmd: assert property (
        s_cmd_valid ##0 !wb_dat_i[3] |=> ##1 drv_o.coast_stop)
        else $error("coast stop not applied");
    chk_void_cmd: assert property (
        s_cmd_void |=> $stable(drv_o.ramp_stop) && $stable(drv_o.coast_stop)
        && $stable(drv_o.freeze)) else $error("invalid command acted upon");
    chk_reset_edge: assert property (
        drv_o.fault_reset |-> rst_cmd)
        else $error("fault reset without command");
endmodule
`default_nettype wire

/* bench/dcsw_wb_master.sv */
/*
 Host model on the far side of the bus: issues classic Wishbone cycles.
 Assumes one clock shared with the slave; a hung slave is cut by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module dcsw_wb_master (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    // The request stays put until ack is sampled high, then it is released.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hF, d};
        @(posedge clk_i);
        while (ack_i !== 1'b1) begin
            @(posedge clk_i);
        end
        q = dat_i;
        {cyc_o, stb_o, we_o} <= 3'b000;
    endtask
endmodule
`default_nettype wire

/* bench/dcsw_tb_top.sv */
/*
 Self-checking bench for dcsw_top: registers, state word, command decode.
 Assumes the bus master model and checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module dcsw_tb_top;
    import dcsw_pkg::*;
    localparam logic [16:0] BASE = 17'h1_8000;
    logic clk_i, rst_i, cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat_o, rdat;
    dcsw_mon_t mon;
    dcsw_drv_t drv;
    logic [15:0] act, sref;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int pulses = 0;
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    dcsw_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat_o), .wb_ack_o(ack),
        .mon_i(mon), .act_freq_i(act), .drv_o(drv), .speed_ref_o(sref));
    dcsw_wb_master i_mst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat_o), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    // ==========================================================
    // Helpers
    task automatic end_sim();
        $display("Checks %0d, errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (drv.fault_reset === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (cycles == 5000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_mst.xfer(1'b1, a, d, rdat);
    endtask
    task automatic rd(input logic [7:0] a);
        i_mst.xfer(1'b0, a, 32'h0000_0000, rdat);
    endtask
    task automatic wcmd(input logic [15:0] c);
        wr(OFS_CMD, {16'h0000, c});
        repeat (2) @(posedge clk_i);
    endtask
    task automatic put(input logic [16:0] m, input logic [15:0] f);
        @(posedge clk_i);
        mon <= m;
        act <= f;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic st_bit(input int b, input logic v);
        rd(OFS_STATE);
        check({31'h0, rdat[b]}, {31'h0, v});
    endtask
    function automatic logic [5:0] exp_drv(input logic [15:0] c);
        logic jw;
        jw = !c[4] && c[3:0] == 4'hF;
        return {!c[0] || !c[6], !c[1] || !c[3], (!c[2] || !c[4]) && !jw, !c[5], c[8] && jw,
                c[9] && jw};
    endfunction
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd(OFS_CFG);
        check(rdat, 32'h0000_0000);
        rd(OFS_LIM);
        check(rdat, 32'h4000_C000);
        rd(8'h20);
        check(rdat, 32'h0000_0000);
    endtask
    task automatic t_state();
        int tk[10] = '{11, 10, 9, 8, 7, 6, 5, 4, 3, 12};
        int tb[10] = '{7, 9, 9, 11, 12, 13, 14, 15, 15, 4};
        for (int i = 0; i < 10; i++) begin
            put(BASE | (17'h1 << tk[i]), 16'h0000);
            st_bit(tb[i], tb[i] != 9);
            put(BASE, 16'h0000);
            st_bit(tb[i], tb[i] == 9);
        end
        st_bit(0, 1'b1);
        for (int k = 1; k < 3; k++) begin
            put(BASE | 17'h0800 | (17'h1 << k), 16'h2000);
            rd(OFS_STATE);
            check(rdat, 32'h0000_0000);
        end
        put(BASE, 16'h0000);
    endtask
    task automatic t_trip();
        put(BASE | 17'h6000, 16'h0000);
        st_bit(6, 1'b1);
        put(BASE, 16'h0000);
        st_bit(3, 1'b1);
        st_bit(0, 1'b0);
        wcmd(16'h047F);
        st_bit(3, 1'b1);
        wcmd(16'h04FF);
        wcmd(16'h04FF);
        st_bit(3, 1'b0);
        check(32'(pulses), 32'h0000_0001);
    endtask
    task automatic t_cmd();
        logic [15:0] tc[11] = '{16'h047F, 16'h0477, 16'h046F, 16'h076F, 16'h057F, 16'h045F,
                               16'h043F, 16'h047E, 16'h047D, 16'h047B, 16'h0300};
        logic [5:0] e;
        for (int i = 0; i < 11; i++) begin
            wcmd(tc[i]);
            if (tc[i][10]) begin
                e = exp_drv(tc[i]);
            end
            check({26'h0, drv.ramp_stop, drv.coast_stop, drv.quick_stop, drv.freeze, drv.jog1,
                   drv.jog2}, {26'h0, e});
        end
        rd(OFS_CMD);
        check(rdat, 32'h0000_047B);
        wcmd(16'h647F);
        check({30'h0, drv.setup_sel}, 32'h0000_0000);
        wr(OFS_CFG, 32'h0000_0003);
        wcmd(16'h647F);
        check({30'h0, drv.setup_sel}, 32'h0000_0003);
        wcmd(16'h247F);
        check({30'h0, drv.setup_sel}, 32'h0000_0001);
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CFG, {26'h0, s[1:0], 4'h4});
            wcmd({15'h423F, !s[0]});
            check({31'h0, drv.reverse}, {31'h0, s[0]});
            check({31'h0, drv.zero_relay}, {31'h0, s[0]});
        end
    endtask
    task automatic t_ref();
        wr(OFS_STEP, 32'h0000_0100);
        wr(OFS_REF, 32'h0000_1000);
        for (int i = 0; i < 4; i++) begin
            wcmd({3'b000, i[1:0], 11'h47F});
            check({16'h0, sref}, i[0] ? 32'h0F00 : (i[1] ? 32'h1100 : 32'h1000));
        end
        wr(OFS_REF, 32'h0000_7F80);
        wcmd(16'h147F);
        check({16'h0, sref}, 32'h0000_7FFF);
        wr(OFS_REF, 32'h0000_4000);
        wcmd(16'h047F);
        check({16'h0, sref}, 32'h0000_4000);
        put(BASE, 16'h4000);
        st_bit(8, 1'b1);
        st_bit(10, 1'b0);
        put(BASE, 16'h2000);
        st_bit(8, 1'b0);
        st_bit(10, 1'b1);
        st_bit(11, 1'b1);
        rd(OFS_ACTF);
        check({16'h0, rdat[15:0]}, 32'h0000_2000);
        put(BASE, 16'hC000);
        st_bit(10, 1'b0);
    endtask
    initial begin
        rst_i = 1'b1;
        mon = BASE;
        act = 16'h0000;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_state();
        t_trip();
        t_cmd();
        t_ref();
        end_sim();
    end
endmodule
bind dcsw_top dcsw_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mon_i(mon_i),
    .act_freq_i(act_freq_i), .drv_o(drv_o), .speed_ref_o(speed_ref_o));
`default_nettype wire
